// ===== include/odt_link_if.sv
// link between controller and termination end
// assumes both ends run on mclk
`timescale 1ns/1ps
interface odt_link_if;
    logic odt;       // termination control pin
    logic cke;       // clock enable
    logic wr_cmd;    // write registered
    logic wr_bl8;    // write is burst length 8
    logic rd_cmd;    // read registered
    logic ref_cmd;   // refresh registered
    logic rtt_on;    // termination state
    modport ctrl (output odt, output cke, output wr_cmd, output wr_bl8,
                  output rd_cmd, output ref_cmd, input rtt_on);
    modport dev  (input odt, input cke, input wr_cmd, input wr_bl8,
                  input rd_cmd, input ref_cmd, output rtt_on);
endinterface : odt_link_if

// ===== include/odt_pkg.sv
// package for the termination control timing block
// assumes a single 100 MHz clock (mclk) shared by both ends
package odt_pkg;
    // clock period in picoseconds
    localparam int CLK_PERIOD_PS        = 10000;
    // hold times in clock cycles
    localparam int ODT_MIN_HIGH_BC4     = 4;
    localparam int ODT_MIN_HIGH_BL8     = 6;
    // latency offset: latency = cwl + al - ODTL_OFFSET
    localparam int ODTL_OFFSET          = 2;
    // lead window adds one cycle to the larger latency
    localparam int PDE_LEAD_EXTRA       = 1;
    // asynchronous delays in picoseconds (2 ns .. 8.5 ns)
    localparam int ASYNC_DELAY_MIN_PS   = 2000;
    localparam int ASYNC_DELAY_MAX_PS   = 8500;
    // least delay rounds up, longest rounds down, never below one cycle
    localparam int ASYNC_MIN_CYC_RAW    = (ASYNC_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_CYC_RAW    = ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_TURN_ON_DELAY  = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
    localparam int ASYNC_TURN_OFF_DELAY = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
    // latency field width
    localparam int LAT_W                = 5;
    // default cwl and al
    localparam logic [4:0] CWL_DEFAULT  = 5'h09;
    localparam logic [4:0] AL_DEFAULT   = 5'h00;
    // refresh cycle time in clocks
    localparam logic [7:0] TRFC_DEFAULT = 8'h1A;
endpackage : odt_pkg

// ===== rtl/odt_ctrl.sv
// controller end: drives odt honouring read windows, and hold windows unless a read request drops odt early
// assumes the device end shares mclk
`timescale 1ns/1ps

module odt_ctrl import odt_pkg::*; (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // link
    odt_link_if.ctrl  link,
    // user requests
    input  wire logic term_req,
    input  wire logic wr_req,
    input  wire logic wr_req_bl8,
    input  wire logic rd_req,
    input  wire logic ref_req,
    input  wire logic cke_req,
    input  wire logic [3:0] rd_guard,
    // status
    output logic      odt_state
);
    logic [3:0] hold_reg, hold_next;
    logic [3:0] rdg_reg, rdg_next;
    logic       odt_reg, odt_next;
    logic       wr_reg, wr_next, bl8_reg, bl8_next, rd_reg, rd_next, ref_reg, ref_next, cke_reg, cke_next;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        hold_next = (hold_reg != 4'h0) ? hold_reg - 4'h1 : 4'h0;
        rdg_next  = (rdg_reg != 4'h0) ? rdg_reg - 4'h1 : 4'h0;
        wr_next   = wr_req;
        bl8_next  = wr_req_bl8;
        rd_next   = rd_req;
        ref_next  = ref_req;
        cke_next  = cke_req;
        odt_next  = odt_reg;
        if (rd_req) begin
            rdg_next = rd_guard;
        end
        if (term_req & ~rd_req & (rdg_reg == 4'h0)) begin
            odt_next = 1'b1;
        end else if (hold_reg == 4'h0 || rd_req) begin
            odt_next = 1'b0;
        end
        if (odt_next & ~odt_reg) begin
            hold_next = 4'(ODT_MIN_HIGH_BC4 - 1);
        end
        // write leaves on the link together with odt, so it counts once odt goes high
        if (odt_next & wr_req) begin
            hold_next = wr_req_bl8 ? 4'(ODT_MIN_HIGH_BL8 - 1) : 4'(ODT_MIN_HIGH_BC4 - 1);
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold_reg <= 4'h0;
            rdg_reg  <= 4'h0;
            odt_reg  <= 1'b0;
            wr_reg   <= 1'b0;
            bl8_reg  <= 1'b0;
            rd_reg   <= 1'b0;
            ref_reg  <= 1'b0;
            cke_reg  <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            rdg_reg  <= rdg_next;
            odt_reg  <= odt_next;
            wr_reg   <= wr_next;
            bl8_reg  <= bl8_next;
            rd_reg   <= rd_next;
            ref_reg  <= ref_next;
            cke_reg  <= cke_next;
        end
    end

    assign link.odt     = odt_reg;
    assign link.wr_cmd  = wr_reg;
    assign link.wr_bl8  = bl8_reg;
    assign link.rd_cmd  = rd_reg;
    assign link.ref_cmd = ref_reg;
    assign link.cke     = cke_reg;
    assign odt_state    = odt_reg;
endmodule : odt_ctrl

// ===== rtl/odt_dev.sv
// device end: turns termination on and off from the control pin
// assumes pins come from the controller on the same mclk
`timescale 1ns/1ps

module odt_dev import odt_pkg::*; (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // link
    odt_link_if.dev               link,
    // configuration
    input  wire logic [LAT_W-1:0] cwl,
    input  wire logic [LAT_W-1:0] al,
    input  wire logic             dll_on_pd,
    input  wire logic             dll_locked,
    input  wire logic             rtt_enabled,
    input  wire logic [7:0]       trfc,
    // status
    output logic                  async_mode,
    output logic                  in_transition,
    output logic                  hold_violation
);
    localparam int DLY_DEPTH = 32;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [DLY_DEPTH-1:0] dly_reg, dly_next;
    logic                 rtt_reg, rtt_next;
    logic                 odt_q_reg, odt_q_next;
    logic                 cke_q_reg, cke_q_next;
    logic [3:0]           async_cnt_reg, async_cnt_next;
    logic [7:0]           ref_cnt_reg, ref_cnt_next;
    logic [3:0]           hold_cnt_reg, hold_cnt_next;
    logic                 async_reg, async_next;
    logic                 trans_reg, trans_next;
    logic                 viol_reg, viol_next;
    logic [LAT_W-1:0]     lat;

    // odt latency in cycles
    function automatic logic [LAT_W-1:0] odt_latency(input logic [LAT_W-1:0] c, input logic [LAT_W-1:0] a);
        odt_latency = LAT_W'(c + a - LAT_W'(ODTL_OFFSET));
    endfunction : odt_latency

    assign lat = odt_latency(cwl, al);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        dly_next       = {dly_reg[DLY_DEPTH-2:0], link.odt};
        rtt_next       = rtt_reg;
        odt_q_next     = link.odt;
        cke_q_next     = link.cke;
        async_cnt_next = async_cnt_reg;
        ref_cnt_next   = (ref_cnt_reg != 8'h00) ? ref_cnt_reg - 8'h01 : 8'h00;
        hold_cnt_next  = (hold_cnt_reg != 4'h0) ? hold_cnt_reg - 4'h1 : 4'h0;
        viol_next      = viol_reg;
        trans_next     = 1'b0;
        async_next = ~dll_locked | (~link.cke & ~dll_on_pd);
        trans_next = ~dll_on_pd & link.cke & cke_q_reg & ~async_reg & dll_locked;
        if (link.ref_cmd) begin
            ref_cnt_next = trfc;
        end
        if (~link.cke & ~dll_on_pd & (ref_cnt_reg != 8'h00)) begin
            trans_next = 1'b1;
            async_next = 1'b0;
        end
        if (!rtt_enabled) begin
            rtt_next = 1'b0;
        end else if (async_reg) begin
            if (link.odt != rtt_reg) begin
                if (async_cnt_reg >= 4'(ASYNC_TURN_ON_DELAY - 1)) begin
                    rtt_next       = link.odt;
                    async_cnt_next = 4'h0;
                end else begin
                    async_cnt_next = async_cnt_reg + 4'h1;
                end
            end else begin
                async_cnt_next = 4'h0;
            end
        end else begin
            rtt_next       = (lat == '0) ? link.odt : dly_reg[lat-1];
            async_cnt_next = 4'h0;
        end
        if (link.odt & ~odt_q_reg) begin
            hold_cnt_next = 4'(ODT_MIN_HIGH_BC4 - 1);
        end
        if (link.odt & link.wr_cmd) begin
            hold_cnt_next = link.wr_bl8 ? 4'(ODT_MIN_HIGH_BL8 - 1) : 4'(ODT_MIN_HIGH_BC4 - 1);
        end
        if (~link.odt & odt_q_reg & (hold_cnt_reg != 4'h0)) begin
            viol_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dly_reg       <= '0;
            rtt_reg       <= 1'b0;
            odt_q_reg     <= 1'b0;
            cke_q_reg     <= 1'b0;
            async_cnt_reg <= 4'h0;
            ref_cnt_reg   <= 8'h00;
            hold_cnt_reg  <= 4'h0;
            async_reg     <= 1'b1;
            trans_reg     <= 1'b0;
            viol_reg      <= 1'b0;
        end else begin
            dly_reg       <= dly_next;
            rtt_reg       <= rtt_next;
            odt_q_reg     <= odt_q_next;
            cke_q_reg     <= cke_q_next;
            async_cnt_reg <= async_cnt_next;
            ref_cnt_reg   <= ref_cnt_next;
            hold_cnt_reg  <= hold_cnt_next;
            async_reg     <= async_next;
            trans_reg     <= trans_next;
            viol_reg      <= viol_next;
        end
    end

    assign link.rtt_on    = rtt_reg;
    assign async_mode     = async_reg;
    assign in_transition  = trans_reg;
    assign hold_violation = viol_reg;
endmodule : odt_dev

// ===== tb/odt_link_sva.sv
// checker for the termination link between both ends
// assumes one mclk domain, instanced beside the link
`timescale 1ns/1ps
module odt_link_sva #(parameter int LAT = 7) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // link and mode
    input wire logic odt,
    input wire logic wr_cmd,
    input wire logic wr_bl8,
    input wire logic rd_cmd,
    input wire logic rtt_on,
    input wire logic async_mode
);
    // ------------------------------------------------
    // timing checks
    // ------------------------------------------------
    localparam int DE = LAT;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sync_on_a: assert property ($rose(odt) && !async_mode |-> ##DE !rtt_on ##1 rtt_on)
        else $error("sync turn-on latency wrong");
    sync_off_a: assert property ($fell(odt) && !async_mode |-> ##DE rtt_on ##1 !rtt_on)
        else $error("sync turn-off latency wrong");
    hold_four_a: assert property ($rose(odt) |-> odt [*4])
        else $error("odt dropped before four cycles");
    hold_bl8_a: assert property (wr_cmd && wr_bl8 && odt |-> odt [*6])
        else $error("odt dropped early after bl8 write");
    hold_bc4_a: assert property (wr_cmd && !wr_bl8 && odt |-> odt [*4])
        else $error("odt dropped early after bc4 write");
    read_off_a: assert property (rd_cmd |-> !odt)
        else $error("odt high at read");
    read_guard_a: assert property (rd_cmd |=> !odt [*3])
        else $error("odt back inside read guard");
    async_on_a: assert property ($rose(odt) && async_mode |-> ##[1:3] rtt_on)
        else $error("async turn-on too slow");
    async_off_a: assert property ($fell(odt) && async_mode |-> ##[1:3] !rtt_on)
        else $error("async turn-off too slow");
endmodule : odt_link_sva

// ===== tb/test_ddr3_odt_timing_control.sv
// bench joining controller end and device end
// assumes odt_pkg constants and a 100 MHz mclk
`timescale 1ns/1ps
module test_ddr3_odt_timing_control import odt_pkg::*;;
    localparam int LAT = 9; // cwl 9 plus al 2 minus 2
    logic       mclk, reset_n, dll_on_pd, dll_locked, cke_req;
    logic       term_req, wr_req, wr_req_bl8, rd_req, ref_req;
    logic       async_mode, in_transition, hold_violation, odt_state;
    logic [7:0] n;
    int         bad_count = 0;
    int         checks = 0;
    odt_link_if link ();
    odt_dev odt_dev_inst (.mclk(mclk), .reset_n(reset_n), .link(link), .cwl(CWL_DEFAULT), .al(5'h02),
        .dll_on_pd(dll_on_pd), .dll_locked(dll_locked), .rtt_enabled(1'b1), .trfc(8'h0A),
        .async_mode(async_mode), .in_transition(in_transition), .hold_violation(hold_violation));
    odt_ctrl odt_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .link(link), .term_req(term_req),
        .wr_req(wr_req), .wr_req_bl8(wr_req_bl8), .rd_req(rd_req), .ref_req(ref_req),
        .cke_req(cke_req), .rd_guard(4'h4), .odt_state(odt_state));
    odt_link_sva #(.LAT(LAT)) odt_link_sva_inst (.mclk(mclk), .reset_n(reset_n), .odt(link.odt),
        .wr_cmd(link.wr_cmd), .wr_bl8(link.wr_bl8), .rd_cmd(link.rd_cmd), .rtt_on(link.rtt_on),
        .async_mode(async_mode));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int c);
        repeat (c) @(negedge mclk);
    endtask : tick
    // falling edges until odt (sel 0) or rtt_on (sel 1) reads v
    task automatic wait_for(input logic sel, input logic v, output logic [7:0] c);
        c = 0;
        while (((sel ? link.rtt_on : link.odt) !== v) && c < 40) begin
            tick(1);
            c++;
        end
    endtask : wait_for
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_sync;
        term_req = 1'b1;
        wait_for(1'b0, 1'b1, n);
        wait_for(1'b1, 1'b1, n);
        check("turn-on cycles", n, 8'(LAT + 1));
        term_req = 1'b0;
        wait_for(1'b0, 1'b0, n);
        wait_for(1'b1, 1'b0, n);
        check("turn-off cycles", n, 8'(LAT + 1));
        tick(20);
        $display("sync done");
    endtask : t_sync
    // short request, bc4 write, bl8 write
    task automatic t_hold;
        for (int k = 0; k < 3; k++) begin
            term_req = 1'b1;
            wr_req = (k > 0);
            wr_req_bl8 = (k == 2);
            tick(1);
            {term_req, wr_req, wr_req_bl8} = 3'h0;
            wait_for(1'b0, 1'b1, n);
            wait_for(1'b0, 1'b0, n);
            check("odt high span", n, (k == 2) ? 8'h06 : 8'h04);
            tick(20);
        end
        $display("hold done");
    endtask : t_hold
    task automatic t_read;
        term_req = 1'b1;
        tick(8);
        rd_req = 1'b1;
        tick(1);
        rd_req = 1'b0;
        check("odt at read", link.odt, 1'b0);
        check("odt state at read", odt_state, 1'b0);
        tick(3);
        check("odt in guard", link.odt, 1'b0);
        wait_for(1'b0, 1'b1, n);
        check("odt back", link.odt, 1'b1);
        term_req = 1'b0;
        tick(30);
        $display("read done");
    endtask : t_read
    task automatic t_mode;
        dll_locked = 1'b0;
        tick(4);
        check("async in resync", async_mode, 1'b1);
        term_req = 1'b1;
        wait_for(1'b0, 1'b1, n);
        wait_for(1'b1, 1'b1, n);
        check("async on fast", n < 4, 1'b1);
        tick(6);
        term_req = 1'b0;
        wait_for(1'b0, 1'b0, n);
        wait_for(1'b1, 1'b0, n);
        check("async off fast", n < 4, 1'b1);
        dll_locked = 1'b1;
        tick(6);
        check("sync when locked", async_mode, 1'b0);
        dll_on_pd = 1'b0;
        tick(2);
        check("entry window", in_transition, 1'b1);
        cke_req = 1'b0;
        tick(4);
        check("async dll off pd", async_mode, 1'b1);
        check("window ends", in_transition, 1'b0);
        cke_req = 1'b1;
        tick(6);
        ref_req = 1'b1;
        tick(1);
        {ref_req, cke_req} = 2'h0;
        tick(4);
        check("refresh window", in_transition, 1'b1);
        tick(12);
        check("refresh window end", in_transition, 1'b0);
        {dll_on_pd, cke_req} = 2'h3;
        tick(6);
        check("no window dll on", in_transition, 1'b0);
        check("no hold fault", hold_violation, 1'b0);
        $display("mode done");
    endtask : t_mode
    // ------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {reset_n, term_req, wr_req, wr_req_bl8, rd_req, ref_req} = 6'h00;
        {dll_on_pd, dll_locked, cke_req} = 3'h7;
        tick(8);
        reset_n = 1'b1;
        tick(2);
        t_sync();
        t_hold();
        t_read();
        t_mode();
        wrap_up();
    end
endmodule : test_ddr3_odt_timing_control
